// >>> hw/lane_pm_pkg.sv
// Package of constants and carrier types for the lane power manager
package lane_pm_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int RXDET_INTVL_MS = 12;
	localparam int RXDET_INTVL_CYC = (CLK_HZ / 1000) * RXDET_INTVL_MS;
	localparam int CFG_HOLD_US = 10;
	localparam int CFG_HOLD_CYC = (CLK_HZ / 1_000_000) * CFG_HOLD_US;
	localparam logic [19:0] DPCD_LANE_COUNT = 20'h0_0101;
	localparam logic [19:0] DPCD_POWER_STATE = 20'h0_0600;
	localparam logic [2:0] PWR_D3 = 3'h2;
	localparam logic [4:0] LANES_ONE = 5'h01;
	localparam logic [4:0] LANES_TWO = 5'h02;
	localparam logic [4:0] LANES_FOUR = 5'h04;
	localparam logic [3:0] LANE_MASK_NONE = 4'h0;
	localparam logic [3:0] LANE_MASK_ONE = 4'h1;
	localparam logic [3:0] LANE_MASK_TWO = 4'h3;
	localparam logic [3:0] LANE_MASK_ALL = 4'hf;
	localparam logic [1:0] LVL_ZERO = 2'h0;

	typedef enum logic [1:0] {
		STRAP_GND = 2'b00,
		STRAP_RES = 2'b01,
		STRAP_FLOAT = 2'b10,
		STRAP_VCC = 2'b11
	} strap_level_type;

	typedef enum logic [2:0] {
		U_DISCONNECT = 3'b000,
		U_ZERO = 3'b001,
		U_ONE = 3'b010,
		U_TWO = 3'b011,
		U_THREE = 3'b100
	} link_state_type;

	typedef enum logic [1:0] {
		CFG_POWER_DOWN = 2'b00,
		CFG_USB_ONLY = 2'b01,
		CFG_FOUR_DP = 2'b10,
		CFG_USB_TWO_DP = 2'b11
	} config_type;

	// Physical-layer conditions seen on the USB path
	typedef struct packed {
		logic far_rx_found;
		logic elec_idle;
		logic lfps;
		logic ss_rate;
	} phy_cond_type;

	// One completed native AUX write seen by the snoop front end
	typedef struct packed {
		logic valid;
		logic [19:0] addr;
		logic [7:0] data;
	} aux_write_type;

	// Raw four-level sense: two comparator bits per strap
	typedef struct packed {
		logic [1:0] mode_sel;
		logic [1:0] usb_rx_gain_straps_0;
		logic [1:0] usb_rx_gain_straps_1;
		logic [1:0] usb_host_side_gain_straps_0;
		logic [1:0] usb_host_side_gain_straps_1;
		logic [1:0] dp_gain_straps_0;
		logic [1:0] dp_gain_straps_1;
	} strap_sense_type;

	typedef struct packed {
		logic [3:0] gain_select_one_reg;
		logic [3:0] gain_select_two_reg;
		logic [3:0] host_side_gain_select_reg;
	} gain_regs_type;
endpackage

// >>> hw/lane_power_manager.sv
// Lane power manager: USB state inference, gain gating, AUX lane snoop
// Functional notes
// - Repeat receiver detection on transmit pairs until far-end receiver found.
// - On receiver found, enable receive termination and start redriving.
// - Infer link state U0 to U3 from termination, idle, LFPS, rate.
// - Turn receiver equalization off whenever LFPS is sensed.
// - Without LFPS, apply gain from straps or programmed gain registers.
// - In DisplayPort modes capture native AUX writes to 0x00101, 0x00600.
// - Lane enables follow the lane count most recently written; CFG_USB_TWO_DP caps them at lanes 0-1.
// - Sink power state D3 disables all DisplayPort lanes.
// - Snooping on after reset; disable bit hands lanes to config bits.
// - Pin mode with sink detect high stops snooping, all four lanes on in CFG_FOUR_DP, lanes 0-1 in CFG_USB_TWO_DP.
// - Each four-level strap resolves to exactly one of four levels.
// - Straps captured at reset release; pulls released after hold time.
// - Two straps per path combine into one of sixteen gain settings.
// - Gain registers may override strap-derived settings.
// - Pin mode pins select configuration; default is USB only.
`timescale 1ns/1ps
`default_nettype none
module lane_power_manager (
	input wire logic ref_clk_i, // 50 MHz clock
	input wire logic arst_n_i, // Internal reset, active low
	input wire lane_pm_pkg::phy_cond_type phy_i, // USB line conditions
	input wire lane_pm_pkg::aux_write_type aux_i, // Snooped AUX write
	input wire lane_pm_pkg::strap_sense_type strap_i, // Raw strap sense
	input wire lane_pm_pkg::gain_regs_type gain_regs_i, // Gain registers
	input wire logic gain_override_i, // Use gain registers
	input wire logic snoop_disable_i, // Software snoop disable
	input wire logic [3:0] cfg_lane_en_i, // Lanes when snoop_disable_i set
	input wire logic usb_config_pin_i, // Pin-mode USB select
	input wire logic dp_config_pin_i, // Pin-mode DP select
	input wire logic sink_detect_pin_i, // Sink detect
	input wire lane_pm_pkg::config_type reg_config_i, // Register-mode config
	output logic rx_detect_o, // Receiver detect pulse
	output logic rx_term_en_o, // Receive termination enable
	output logic redrive_en_o, // USB redriving active
	output lane_pm_pkg::link_state_type link_state_o, // Inferred U state
	output logic usb_eq_en_o, // USB equalizer enable
	output logic [3:0] usb_rx_gain_o, // USB upstream gain
	output logic [3:0] usb_host_gain_o, // USB downstream gain
	output logic [3:0] dp_gain_o, // DisplayPort gain
	output logic [3:0] dp_lane_en_o, // DisplayPort lane enables
	output logic strap_pull_en_o, // Internal pulls connected
	output lane_pm_pkg::config_type config_o // Active configuration
);
	import lane_pm_pkg::*;

	// Strap capture one cycle after reset release
	logic captured_reg, captured_next;
	strap_sense_type straps_reg, straps_next;
	logic [31:0] hold_cnt_reg, hold_cnt_next;
	logic pull_reg, pull_next;
	logic pin_mode;
	assign pin_mode = (straps_reg.mode_sel == LVL_ZERO);

	always_comb begin
		captured_next = 1'b1;
		straps_next = straps_reg;
		hold_cnt_next = hold_cnt_reg;
		pull_next = pull_reg;
		if (!captured_reg) begin
			straps_next = strap_i;
		end
		if (captured_reg && pull_reg) begin
			if (hold_cnt_reg == 32'(CFG_HOLD_CYC - 1)) begin
				pull_next = 1'b0;
			end else begin
				hold_cnt_next = hold_cnt_reg + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			captured_reg <= 1'b0;
			straps_reg <= '0;
			hold_cnt_reg <= 32'h0000_0000;
			pull_reg <= 1'b1;
		end else begin
			captured_reg <= captured_next;
			straps_reg <= straps_next;
			hold_cnt_reg <= hold_cnt_next;
			pull_reg <= pull_next;
		end
	end

	// Configuration select
	config_type cfg_reg, cfg_next;
	always_comb begin
		cfg_next = cfg_reg;
		if (captured_reg) begin
			if (pin_mode) begin
				cfg_next = config_type'({dp_config_pin_i, usb_config_pin_i});
			end else begin
				cfg_next = reg_config_i;
			end
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_reg <= CFG_USB_ONLY;
		end else begin
			cfg_reg <= cfg_next;
		end
	end
	logic usb_on, dp_on;
	assign usb_on = (cfg_reg == CFG_USB_ONLY) || (cfg_reg == CFG_USB_TWO_DP);
	assign dp_on = (cfg_reg == CFG_FOUR_DP) || (cfg_reg == CFG_USB_TWO_DP);

	// USB receiver detection and link state inference
	logic [31:0] det_cnt_reg, det_cnt_next;
	logic det_pulse_reg, det_pulse_next;
	logic term_reg, term_next;
	link_state_type ust_reg, ust_next;
	always_comb begin
		det_cnt_next = det_cnt_reg;
		det_pulse_next = 1'b0;
		term_next = term_reg;
		ust_next = ust_reg;
		if (!usb_on) begin
			det_cnt_next = 32'h0000_0000;
			term_next = 1'b0;
			ust_next = U_DISCONNECT;
		end else if (!term_reg) begin
			// Probe at interval start: a receiver present at power-up is found at once
			if (det_cnt_reg == 32'h0000_0000) begin
				det_pulse_next = 1'b1;
			end
			if (det_cnt_reg == 32'(RXDET_INTVL_CYC - 1)) begin
				det_cnt_next = 32'h0000_0000;
			end else begin
				det_cnt_next = det_cnt_reg + 32'h0000_0001;
			end
			if (det_pulse_reg && phy_i.far_rx_found) begin
				term_next = 1'b1;
				ust_next = U_ZERO;
			end
		end else if (!phy_i.far_rx_found) begin
			term_next = 1'b0;
			det_cnt_next = 32'h0000_0000;
			ust_next = U_DISCONNECT;
		end else begin
			case (ust_reg)
				U_ZERO: begin
					if (phy_i.elec_idle) begin
						ust_next = phy_i.ss_rate ? U_ONE : U_TWO;
					end
				end
				U_ONE: begin
					if (phy_i.lfps || !phy_i.elec_idle) begin
						ust_next = U_ZERO;
					end else if (!phy_i.ss_rate) begin
						ust_next = U_TWO;
					end
				end
				U_TWO: begin
					if (phy_i.lfps || !phy_i.elec_idle) begin
						ust_next = U_ZERO;
					end else if (!phy_i.ss_rate && !rx_detect_o) begin
						ust_next = U_THREE;
					end
				end
				U_THREE: begin
					if (phy_i.lfps) begin
						ust_next = U_ZERO;
					end
				end
				default: ust_next = U_ZERO;
			endcase
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			det_cnt_reg <= 32'h0000_0000;
			det_pulse_reg <= 1'b0;
			term_reg <= 1'b0;
			ust_reg <= U_DISCONNECT;
		end else begin
			det_cnt_reg <= det_cnt_next;
			det_pulse_reg <= det_pulse_next;
			term_reg <= term_next;
			ust_reg <= ust_next;
		end
	end
	assign rx_detect_o = det_pulse_reg;
	assign rx_term_en_o = term_reg;
	assign redrive_en_o = term_reg;
	assign link_state_o = ust_reg;

	// Equalization gain and LFPS gating
	logic eq_en_reg, eq_en_next;
	logic [3:0] g_usb_reg, g_usb_next, g_host_reg, g_host_next;
	logic [3:0] g_dp_reg, g_dp_next;
	always_comb begin
		eq_en_next = term_reg && !phy_i.lfps;
		g_usb_next = {straps_reg.usb_rx_gain_straps_1,
			straps_reg.usb_rx_gain_straps_0};
		g_host_next = {straps_reg.usb_host_side_gain_straps_1,
			straps_reg.usb_host_side_gain_straps_0};
		g_dp_next = {straps_reg.dp_gain_straps_1,
			straps_reg.dp_gain_straps_0};
		if (gain_override_i && !pin_mode) begin
			g_usb_next = gain_regs_i.gain_select_one_reg;
			g_host_next = gain_regs_i.host_side_gain_select_reg;
			g_dp_next = gain_regs_i.gain_select_two_reg;
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			eq_en_reg <= 1'b0;
			g_usb_reg <= 4'h0;
			g_host_reg <= 4'h0;
			g_dp_reg <= 4'h0;
		end else begin
			eq_en_reg <= eq_en_next;
			g_usb_reg <= g_usb_next;
			g_host_reg <= g_host_next;
			g_dp_reg <= g_dp_next;
		end
	end
	assign usb_eq_en_o = eq_en_reg;
	assign usb_rx_gain_o = g_usb_reg;
	assign usb_host_gain_o = g_host_reg;
	assign dp_gain_o = g_dp_reg;

	// AUX snoop and lane enables
	logic [4:0] lane_cnt_reg, lane_cnt_next;
	logic d3_reg, d3_next;
	logic [3:0] lanes_reg, lanes_next;
	logic [3:0] snoop_mask;
	logic snoop_on;
	assign snoop_on = !snoop_disable_i && !(pin_mode && sink_detect_pin_i);
	always_comb begin
		lane_cnt_next = lane_cnt_reg;
		d3_next = d3_reg;
		if (dp_on && snoop_on && aux_i.valid) begin
			if (aux_i.addr == DPCD_LANE_COUNT) begin
				lane_cnt_next = aux_i.data[4:0];
			end else if (aux_i.addr == DPCD_POWER_STATE) begin
				d3_next = (aux_i.data[2:0] == PWR_D3);
			end
		end
		if (lane_cnt_reg == LANES_ONE) begin
			snoop_mask = LANE_MASK_ONE;
		end else if (lane_cnt_reg == LANES_TWO) begin
			snoop_mask = LANE_MASK_TWO;
		end else if (lane_cnt_reg == LANES_FOUR) begin
			snoop_mask = LANE_MASK_ALL;
		end else begin
			snoop_mask = LANE_MASK_NONE;
		end
		if (!dp_on) begin
			lanes_next = LANE_MASK_NONE;
		end else if (pin_mode && sink_detect_pin_i) begin
			lanes_next = LANE_MASK_ALL;
		end else if (snoop_disable_i) begin
			lanes_next = cfg_lane_en_i;
		end else if (d3_reg) begin
			lanes_next = LANE_MASK_NONE;
		end else begin
			lanes_next = snoop_mask;
		end
		if (cfg_reg == CFG_USB_TWO_DP) begin
			lanes_next = lanes_next & LANE_MASK_TWO;
		end
	end
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lane_cnt_reg <= LANES_FOUR;
			d3_reg <= 1'b0;
			lanes_reg <= LANE_MASK_NONE;
		end else begin
			lane_cnt_reg <= lane_cnt_next;
			d3_reg <= d3_next;
			lanes_reg <= lanes_next;
		end
	end
	assign dp_lane_en_o = lanes_reg;
	assign strap_pull_en_o = pull_reg;
	assign config_o = cfg_reg;

	a_lfps_eq_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		phy_i.lfps |=> !usb_eq_en_o) else $error("eq on during lfps");
	a_eq_on_idle: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(rx_term_en_o && !phy_i.lfps) |=> usb_eq_en_o)
		else $error("eq off without lfps");
	a_term_needs_det: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i)
		$rose(rx_term_en_o) |-> $past(rx_detect_o))
		else $error("termination without detect");
	a_d3_lanes_off: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i)
		(d3_reg && snoop_on && dp_on) |=> dp_lane_en_o == 4'h0)
		else $error("lanes on in d3");
	a_sink_all_lanes: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i)
		(pin_mode && sink_detect_pin_i && cfg_reg == CFG_FOUR_DP) |=>
		dp_lane_en_o == 4'hf) else $error("sink detect lanes");
	a_lane_count: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i)
		(aux_i.valid && dp_on && snoop_on && aux_i.addr == DPCD_LANE_COUNT
		&& aux_i.data == 8'h01) |=> lane_cnt_reg == 5'h01)
		else $error("lane count not taken");
	a_one_lane: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(lane_cnt_reg == 5'h01 && !d3_reg && snoop_on && dp_on) |=>
		dp_lane_en_o == 4'h1) else $error("one lane mask");
	a_snoop_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(snoop_disable_i && aux_i.valid) |=> $stable(lane_cnt_reg))
		else $error("snoop while disabled");
	a_det_repeat: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		rx_detect_o |=> !rx_detect_o) else $error("detect not a pulse");
	a_straps_hold: assert property (@(posedge ref_clk_i)
		disable iff (!arst_n_i)
		captured_reg |=> $stable(straps_reg))
		else $error("straps changed");
endmodule
`default_nettype wire

// >>> dv/far_side_model.sv
// Far-side model: USB far-end receiver and DisplayPort AUX source
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
	input wire logic ref_clk_i, // Clock
	output wire lane_pm_pkg::phy_cond_type phy_o, // Line conditions
	output var lane_pm_pkg::aux_write_type aux_o // Completed AUX writes
);
	import lane_pm_pkg::*;
	logic present = 1'b1;
	logic idle = 1'b0;
	logic lfps = 1'b0;
	logic rate = 1'b0;
	assign phy_o = {present, idle, lfps, rate};
	initial aux_o = '0;
	// One write pulse, then a spare edge before the next may start
	task automatic aux_write(input logic [19:0] addr, input logic [7:0] data);
		aux_o = {1'b1, addr, data};
		@(negedge ref_clk_i);
		aux_o = {1'b0, ~addr, ~data};
		@(negedge ref_clk_i);
	endtask
endmodule
`default_nettype wire

// >>> dv/lane_power_manager_test.sv
// Self-checking bench for the lane power manager
`timescale 1ns/1ps
`default_nettype none
module lane_power_manager_test;
	import lane_pm_pkg::*;
	typedef struct packed {
		logic [19:0] addr;
		logic [7:0] data;
		logic [3:0] lanes;
	} aux_row_type;
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	strap_sense_type strap = {2'h3, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h3};
	gain_regs_type gregs = '0;
	logic ovr = 1'b0;
	logic snoop_dis = 1'b0;
	logic [3:0] cfg_lanes = 4'h0;
	logic usb_pin = 1'b1;
	logic dp_pin = 1'b0;
	logic sink_pin = 1'b0;
	config_type reg_cfg = CFG_USB_TWO_DP;
	logic rx_det, term, redrive, eq_en, pull_en;
	link_state_type lstate;
	logic [3:0] g_rx, g_host, g_dp, lanes;
	config_type cfg;
	phy_cond_type phy;
	aux_write_type aux;
	int mismatches = 0;
	int comparisons = 0;
	aux_row_type rows [8] = '{
		'{DPCD_LANE_COUNT, 8'h01, 4'h1},
		'{DPCD_LANE_COUNT, 8'h02, 4'h3},
		'{DPCD_LANE_COUNT, 8'h04, 4'h3},
		'{DPCD_POWER_STATE, 8'h02, 4'h0},
		'{DPCD_POWER_STATE, 8'h01, 4'h3},
		'{DPCD_LANE_COUNT, 8'h03, 4'h0},
		'{20'h0_0102, 8'h01, 4'h0},
		'{DPCD_LANE_COUNT, 8'h02, 4'h3}};
	int pin_order [4] = '{0, 1, 3, 2};
	config_type pin_cfg [4] = '{CFG_POWER_DOWN, CFG_USB_ONLY, CFG_FOUR_DP,
		CFG_USB_TWO_DP};

	always #10 ref_clk_i = ~ref_clk_i;

	far_side_model far_side_model_i (
		.ref_clk_i(ref_clk_i),
		.phy_o(phy),
		.aux_o(aux)
	);

	lane_power_manager lane_power_manager_i (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.phy_i(phy),
		.aux_i(aux),
		.strap_i(strap),
		.gain_regs_i(gregs),
		.gain_override_i(ovr),
		.snoop_disable_i(snoop_dis),
		.cfg_lane_en_i(cfg_lanes),
		.usb_config_pin_i(usb_pin),
		.dp_config_pin_i(dp_pin),
		.sink_detect_pin_i(sink_pin),
		.reg_config_i(reg_cfg),
		.rx_detect_o(rx_det),
		.rx_term_en_o(term),
		.redrive_en_o(redrive),
		.link_state_o(lstate),
		.usb_eq_en_o(eq_en),
		.usb_rx_gain_o(g_rx),
		.usb_host_gain_o(g_host),
		.dp_gain_o(g_dp),
		.dp_lane_en_o(lanes),
		.strap_pull_en_o(pull_en),
		.config_o(cfg)
	);

	task automatic check(input string name, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask

	task automatic do_reset(input logic [1:0] mode);
		arst_n_i = 1'b0;
		strap.mode_sel = mode;
		cyc(16);
		check("config_rst", 32'(CFG_USB_ONLY), 32'(cfg));
		check("pull_rst", 32'h1, 32'(pull_en));
		check("lanes_rst", 32'h0, 32'(lanes));
		arst_n_i = 1'b1;
		cyc(1);
		check("rx_detect", 32'h1, 32'(rx_det));
		check("term_wait", 32'h0, 32'(term));
		cyc(1);
		check("term", 32'h1, 32'(term));
		check("redrive", 32'h1, 32'(redrive));
		check("state_u0", 32'(U_ZERO), 32'(lstate));
	endtask

	task automatic aux_check(input aux_row_type r);
		far_side_model_i.aux_write(r.addr, r.data);
		cyc(2);
		check("dp_lane_en", 32'(r.lanes), 32'(lanes));
	endtask

	initial begin
		int n;
		do_reset(2'h3);
		fork
			begin
				cyc(480);
				check("pull_hold", 32'h1, 32'(pull_en));
				cyc(30);
				check("pull_off", 32'h0, 32'(pull_en));
			end
			begin
				n = 0;
				repeat (500) begin
					cyc(1);
					if (rx_det !== 1'b0)
						n++;
				end
				check("rx_det_quiet", 32'h0, 32'(n));
				check("term_hold", 32'h1, 32'(term));
				check("redrive_hold", 32'h1, 32'(redrive));
				check("state_hold_u0", 32'(U_ZERO), 32'(lstate));
			end
		join
		check("gain_rx", 32'h9, 32'(g_rx));
		check("gain_host", 32'h3, 32'(g_host));
		check("gain_dp", 32'hc, 32'(g_dp));
		ovr = 1'b1;
		gregs = {4'h5, 4'ha, 4'h6};
		cyc(2);
		check("ovr_rx", 32'h5, 32'(g_rx));
		check("ovr_dp", 32'ha, 32'(g_dp));
		check("ovr_host", 32'h6, 32'(g_host));
		ovr = 1'b0;
		check("eq_on", 32'h1, 32'(eq_en));
		far_side_model_i.idle = 1'b1;
		far_side_model_i.rate = 1'b1;
		cyc(2);
		check("state_u1", 32'(U_ONE), 32'(lstate));
		far_side_model_i.rate = 1'b0;
		cyc(1);
		check("state_u2", 32'(U_TWO), 32'(lstate));
		cyc(1);
		check("state_u3", 32'(U_THREE), 32'(lstate));
		far_side_model_i.idle = 1'b0;
		cyc(3);
		check("state_hold", 32'(U_THREE), 32'(lstate));
		far_side_model_i.lfps = 1'b1;
		cyc(2);
		check("state_wake", 32'(U_ZERO), 32'(lstate));
		check("eq_lfps", 32'h0, 32'(eq_en));
		far_side_model_i.lfps = 1'b0;
		cyc(2);
		check("eq_back", 32'h1, 32'(eq_en));
		for (int i = 0; i < 8; i++)
			aux_check(rows[i]);
		reg_cfg = CFG_FOUR_DP;
		cyc(2);
		aux_check(aux_row_type'{DPCD_LANE_COUNT, 8'h04, 4'hf});
		snoop_dis = 1'b1;
		cfg_lanes = 4'h5;
		cyc(2);
		check("cfg_lanes", 32'h5, 32'(lanes));
		aux_check(aux_row_type'{DPCD_LANE_COUNT, 8'h01, 4'h5});
		snoop_dis = 1'b0;
		do_reset(2'h0);
		for (int i = 0; i < 4; i++) begin
			{dp_pin, usb_pin} = 2'(pin_order[i]);
			cyc(250);
			check("pin_cfg", 32'(pin_cfg[pin_order[i]]), 32'(cfg));
		end
		sink_pin = 1'b1;
		cyc(2);
		aux_check(aux_row_type'{DPCD_LANE_COUNT, 8'h01, 4'hf});
		sink_pin = 1'b0;
		cyc(2);
		aux_check(aux_row_type'{DPCD_LANE_COUNT, 8'h02, 4'h3});
		report_and_stop();
	end

	initial begin
		cyc(20000);
		mismatches++;
		report_and_stop();
	end
endmodule
`default_nettype wire
